// ==== verilog/status_mem_regs.svh ====
`ifndef STATUS_MEM_REGS_SVH
`define STATUS_MEM_REGS_SVH

// ==========================================================================
// register offsets
`define STATUS_OFFSET 8'hC5
`define MEMCFG_OFFSET 8'hC6
`define UNLOCK_KEY_OFFSET 8'hC7

// ==========================================================================
// status register field positions
`define ST_PF_BIT 7
`define ST_HP_BIT 6
`define ST_LP_BIT 5
`define ST_RSVD_BIT 4
`define ST_P1TX_BIT 3
`define ST_P1RX_BIT 2
`define ST_P0TX_BIT 1
`define ST_P0RX_BIT 0

// ==========================================================================
// memory configuration field positions and reset value
`define MC_MAP_HI_BIT 7
`define MC_MAP_LO_BIT 6
`define MC_CAN_BIT 5
`define MC_ONE_BIT 4
`define MC_MERGE_HI_BIT 3
`define MC_MERGE_LO_BIT 0
`define MEMCFG_RESET 8'h10
`define STATUS_RESET 7'h00

// ==========================================================================
// timed access keys and windows, in core clock cycles
`define UNLOCK_KEY_FIRST 8'hAA
`define UNLOCK_KEY_SECOND 8'h55
`define UNLOCK_ARM_CYCLES 2'h3
`define UNLOCK_OPEN_CYCLES 2'h3

// ==========================================================================
// address pages: sram by 4kB page, can buffers by 256-byte page
`define SRAM_PAGE_TOP 12'h00F
`define SRAM_PAGE_LOW 12'h000
`define SRAM_PAGE_EXT 12'h400
`define CAN0_PAGE_LOW 16'h00EE
`define CAN1_PAGE_LOW 16'h00EF
`define CAN0_PAGE_EXT 16'h4010
`define CAN1_PAGE_EXT 16'h4011

`endif

// ==== verilog/status_mem_pkg.sv ====
package status_mem_pkg;

    // placement of the on-chip sram
    typedef enum logic [1:0] {
        SRAM_DATA_TOP = 2'b00,
        SRAM_DATA_LOW = 2'b01,
        SRAM_DATA_EXT = 2'b10,
        SRAM_SHARED_EXT = 2'b11
    } sram_map_t;

    // timed access sequencer
    typedef enum logic [1:0] {
        LOCK_IDLE = 2'b00,
        LOCK_ARMED = 2'b01,
        LOCK_OPEN = 2'b10
    } unlock_state_t;

endpackage

// ==== verilog/sticky_flags.sv ====
module sticky_flags #(
    parameter int W = 7
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);

    // set wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= (q & ~clr) | set;
        end
    end

endmodule

// ==== verilog/timed_access_unlock.sv ====
`include "status_mem_regs.svh"

module timed_access_unlock (
    input wire logic clk,
    input wire logic rst,
    input wire logic key_wr,
    input wire logic [7:0] key_wdata,
    output logic window_open
);
    import status_mem_pkg::*;

    unlock_state_t state_r;
    logic [1:0] cnt_r;

    // ======================================================================
    // key sequence: first key arms, second key within the arm time opens
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= LOCK_IDLE;
            cnt_r <= 2'h0;
        end else if (key_wr && key_wdata == `UNLOCK_KEY_FIRST) begin
            state_r <= LOCK_ARMED;
            cnt_r <= `UNLOCK_ARM_CYCLES;
        end else if (key_wr && key_wdata == `UNLOCK_KEY_SECOND && state_r == LOCK_ARMED) begin
            state_r <= LOCK_OPEN;
            cnt_r <= `UNLOCK_OPEN_CYCLES;
        end else begin
            unique case (state_r)
                LOCK_IDLE: begin
                    cnt_r <= 2'h0;
                end
                LOCK_ARMED, LOCK_OPEN: begin
                    // a wrong key drops the arming; open windows just run out
                    if ((key_wr && state_r == LOCK_ARMED) || cnt_r == 2'h1) begin
                        state_r <= LOCK_IDLE;
                        cnt_r <= 2'h0;
                    end else begin
                        cnt_r <= cnt_r - 2'h1;
                    end
                end
                default: begin
                    state_r <= LOCK_IDLE;
                    cnt_r <= 2'h0;
                end
            endcase
        end
    end

    assign window_open = (state_r == LOCK_OPEN);

    chk_window_three_cycles: assert property (@(posedge clk) disable iff (rst)
        (key_wr && key_wdata == `UNLOCK_KEY_SECOND && state_r == LOCK_ARMED) |=> window_open [*3])
        else $error("timed access window shorter than three cycles");

    chk_window_closes: assert property (@(posedge clk) disable iff (rst)
        (key_wr && key_wdata == `UNLOCK_KEY_SECOND && state_r == LOCK_ARMED) ##1 (!key_wr) [*3]
        |=> !window_open)
        else $error("timed access window longer than three cycles");

endmodule

// ==== verilog/status_and_memory_config_regs.sv ====
`include "status_mem_regs.svh"

module status_and_memory_config_regs (
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // interrupt service tracking
    input wire logic pf_isr_enter,
    input wire logic hp_isr_enter,
    input wire logic lp_isr_enter,
    input wire logic return_from_interrupt,
    // serial port activity
    input wire logic port0_tx_start,
    input wire logic port0_tx_done_flag,
    input wire logic port0_rx_start,
    input wire logic port0_rx_done_flag,
    input wire logic port1_tx_start,
    input wire logic port1_tx_done_flag,
    input wire logic port1_rx_start,
    input wire logic port1_rx_done_flag,
    // stack extension lockout
    input wire logic stack_extension_enable,
    output logic stack_ext_set_allowed,
    // memory map decode
    input wire logic [23:0] data_addr,
    input wire logic [23:0] code_addr,
    output status_mem_pkg::sram_map_t onchip_sram_map,
    output logic can_buffer_placement,
    output logic [3:0] merged_chip_enable_sel,
    output logic sram_data_hit,
    output logic sram_code_hit,
    output logic can0_hit,
    output logic can1_hit,
    // external strobe steering
    input wire logic [3:0] chip_enable_enabled,
    input wire logic [3:0] chip_enable_select,
    input wire logic external_data_move_rd,
    input wire logic external_code_rd,
    output logic program_store_strobe,
    output logic read_strobe,
    // status bits for the clock control logic
    output logic [2:0] in_service,
    output logic [3:0] serial_active,
    output logic serial_any_active
);
    import status_mem_pkg::*;

    logic [6:0] flag_set;
    logic [6:0] flag_clr;
    logic [6:0] flag_q;
    logic window_open;
    logic [7:0] memcfg_r;
    logic [7:0] memcfg_nxt;
    logic [7:0] reg_rdata_r;
    logic [1:0] map_req;
    logic memcfg_wr;
    logic key_wr;
    logic merged_hit;
    logic sram_data_hit_r;
    logic sram_code_hit_r;
    logic can0_hit_r;
    logic can1_hit_r;
    logic pss_r;
    logic rds_r;
    logic stack_ok_r;
    logic any_act_r;

    // ======================================================================
    // in-service and serial activity flags
    // a return clears only the highest level that is in service
    always_comb begin
        flag_set = {pf_isr_enter, hp_isr_enter, lp_isr_enter,
                    port1_tx_start, port1_rx_start, port0_tx_start, port0_rx_start};
        flag_clr[6] = return_from_interrupt;
        flag_clr[5] = return_from_interrupt & ~flag_q[6];
        flag_clr[4] = return_from_interrupt & ~flag_q[6] & ~flag_q[5];
        flag_clr[3] = port1_tx_done_flag;
        flag_clr[2] = port1_rx_done_flag;
        flag_clr[1] = port0_tx_done_flag;
        flag_clr[0] = port0_rx_done_flag;
    end

    sticky_flags #(
        .W(7)
    ) u_flags (
        .clk(clk),
        .rst(rst),
        .set(flag_set),
        .clr(flag_clr),
        .q(flag_q)
    );

    assign in_service = flag_q[6:4];
    assign serial_active = flag_q[3:0];

    // summary for the clock divider guard, which must hold off while set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            any_act_r <= 1'b0;
        end else begin
            any_act_r <= |flag_set[3:0] | |(flag_q[3:0] & ~flag_clr[3:0]);
        end
    end

    assign serial_any_active = any_act_r;

    // ======================================================================
    // timed access key
    assign key_wr = reg_wr && reg_addr == `UNLOCK_KEY_OFFSET;

    timed_access_unlock u_unlock (
        .clk(clk),
        .rst(rst),
        .key_wr(key_wr),
        .key_wdata(reg_wdata),
        .window_open(window_open)
    );

    // ======================================================================
    // memory configuration register
    assign memcfg_wr = reg_wr && reg_addr == `MEMCFG_OFFSET;
    assign map_req = reg_wdata[`MC_MAP_HI_BIT:`MC_MAP_LO_BIT];

    // next value: protected write with sram map lockout
    always_comb begin
        memcfg_nxt = memcfg_r;
        if (memcfg_wr && window_open) begin
            memcfg_nxt = reg_wdata;
            if (map_req == SRAM_SHARED_EXT && stack_extension_enable) begin
                memcfg_nxt[`MC_MAP_HI_BIT:`MC_MAP_LO_BIT] = memcfg_r[`MC_MAP_HI_BIT:`MC_MAP_LO_BIT];
            end
        end
        memcfg_nxt[`MC_ONE_BIT] = 1'h1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            memcfg_r <= `MEMCFG_RESET;
        end else begin
            memcfg_r <= memcfg_nxt;
        end
    end

    // stack extension may set only while the map is not shared
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stack_ok_r <= 1'h1;
        end else begin
            stack_ok_r <= memcfg_nxt[`MC_MAP_HI_BIT:`MC_MAP_LO_BIT] != SRAM_SHARED_EXT;
        end
    end

    assign stack_ext_set_allowed = stack_ok_r;
    assign onchip_sram_map = sram_map_t'(memcfg_r[`MC_MAP_HI_BIT:`MC_MAP_LO_BIT]);
    assign can_buffer_placement = memcfg_r[`MC_CAN_BIT];
    assign merged_chip_enable_sel = memcfg_r[`MC_MERGE_HI_BIT:`MC_MERGE_LO_BIT];

    // ======================================================================
    // read port: data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `STATUS_OFFSET: reg_rdata_r <= {flag_q[6:4], 1'h0, flag_q[3:0]};
                `MEMCFG_OFFSET: reg_rdata_r <= memcfg_r;
                default: reg_rdata_r <= 8'h00; // key register and unmapped
            endcase
        end else begin
            reg_rdata_r <= 8'h00;
        end
    end

    assign reg_rdata = reg_rdata_r;

    // ======================================================================
    // address decode of sram and can buffers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sram_data_hit_r <= 1'b0;
            sram_code_hit_r <= 1'b0;
        end else begin
            unique case (onchip_sram_map)
                SRAM_DATA_TOP: sram_data_hit_r <= data_addr[23:12] == `SRAM_PAGE_TOP;
                SRAM_DATA_LOW: sram_data_hit_r <= data_addr[23:12] == `SRAM_PAGE_LOW;
                SRAM_DATA_EXT, SRAM_SHARED_EXT: sram_data_hit_r <= data_addr[23:12] == `SRAM_PAGE_EXT;
            endcase
            sram_code_hit_r <= onchip_sram_map == SRAM_SHARED_EXT && code_addr[23:12] == `SRAM_PAGE_EXT;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            can0_hit_r <= 1'b0;
            can1_hit_r <= 1'b0;
        end else if (can_buffer_placement) begin
            can0_hit_r <= data_addr[23:8] == `CAN0_PAGE_EXT;
            can1_hit_r <= data_addr[23:8] == `CAN1_PAGE_EXT;
        end else begin
            can0_hit_r <= data_addr[23:8] == `CAN0_PAGE_LOW;
            can1_hit_r <= data_addr[23:8] == `CAN1_PAGE_LOW;
        end
    end

    assign sram_data_hit = sram_data_hit_r;
    assign sram_code_hit = sram_code_hit_r;
    assign can0_hit = can0_hit_r;
    assign can1_hit = can1_hit_r;

    // ======================================================================
    // external strobe steering for merged chip enables
    assign merged_hit = |(chip_enable_select & chip_enable_enabled & merged_chip_enable_sel);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pss_r <= 1'b0;
            rds_r <= 1'b0;
        end else begin
            pss_r <= external_code_rd | (external_data_move_rd & merged_hit);
            rds_r <= external_data_move_rd & ~merged_hit;
        end
    end

    assign program_store_strobe = pss_r;
    assign read_strobe = rds_r;

    // ======================================================================
    // checks
    chk_locked_write_ignored: assert property (@(posedge clk) disable iff (rst)
        (memcfg_wr && !window_open) |=> memcfg_r == $past(memcfg_r))
        else $error("memory config changed outside timed window");

    chk_open_write_taken: assert property (@(posedge clk) disable iff (rst)
        (memcfg_wr && window_open && map_req != SRAM_SHARED_EXT)
        |=> memcfg_r == ($past(reg_wdata) | `MEMCFG_RESET))
        else $error("timed write to memory config not taken");

    chk_shared_map_lockout: assert property (@(posedge clk) disable iff (rst)
        (memcfg_wr && window_open && map_req == SRAM_SHARED_EXT && stack_extension_enable)
        |=> onchip_sram_map == $past(onchip_sram_map) ##1 !stack_ext_set_allowed || $past(onchip_sram_map, 2) != SRAM_SHARED_EXT)
        else $error("shared sram map taken while stack extension set");

    chk_bit4_reads_one: assert property (@(posedge clk) disable iff (rst)
        (reg_rd && reg_addr == `MEMCFG_OFFSET) |=> reg_rdata[`MC_ONE_BIT] && reg_rdata == memcfg_r)
        else $error("memory config read back wrong");

    chk_nested_return: assert property (@(posedge clk) disable iff (rst)
        (flag_q[6] && flag_q[5] && return_from_interrupt && !pf_isr_enter)
        |=> !in_service[2] && in_service[1])
        else $error("return did not clear only the highest level");

    chk_low_return: assert property (@(posedge clk) disable iff (rst)
        (flag_q[6:4] == 3'b001 && return_from_interrupt && !lp_isr_enter) |=> in_service == 3'b000)
        else $error("low level not cleared by return");

    chk_tx_done_clears: assert property (@(posedge clk) disable iff (rst)
        (port1_tx_done_flag && !port1_tx_start) |=> !serial_active[3])
        else $error("port 1 transmit activity not cleared");

    chk_rx_done_clears: assert property (@(posedge clk) disable iff (rst)
        (port1_rx_done_flag && !port1_rx_start) |=> !serial_active[2])
        else $error("port 1 receive activity not cleared");

    chk_p0_tx_clears: assert property (@(posedge clk) disable iff (rst)
        (port0_tx_done_flag && !port0_tx_start) |=> !serial_active[1])
        else $error("port 0 transmit activity not cleared");

    chk_pf_return_clears: assert property (@(posedge clk) disable iff (rst)
        (in_service[2] && return_from_interrupt && !pf_isr_enter) |=> !in_service[2])
        else $error("power-fail level not cleared by return");

    chk_start_beats_done: assert property (@(posedge clk) disable iff (rst)
        (port0_rx_start && port0_rx_done_flag) |=> serial_active[0] && serial_any_active)
        else $error("receive start lost against done");

    chk_merged_strobe: assert property (@(posedge clk) disable iff (rst)
        (external_data_move_rd && merged_hit) |=> program_store_strobe && !read_strobe)
        else $error("merged data read used the read strobe");

    chk_unenabled_ce: assert property (@(posedge clk) disable iff (rst)
        (external_data_move_rd && (chip_enable_select & chip_enable_enabled) == 4'h0) |=> read_strobe)
        else $error("merge bit acted on a disabled chip enable");

    chk_can_low_decode: assert property (@(posedge clk) disable iff (rst)
        (!can_buffer_placement && data_addr[23:8] == `CAN1_PAGE_LOW) |=> can1_hit && !can0_hit)
        else $error("can block 1 low decode missed");

    chk_status_write_ignored: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && reg_addr == `STATUS_OFFSET && flag_set == 7'h00 && flag_clr == 7'h00)
        |=> {in_service, serial_active} == $past({in_service, serial_active}))
        else $error("status write changed status");

endmodule

// ==== bench/status_and_memory_config_regs_tb_top.sv ====
`include "status_mem_regs.svh"

module status_and_memory_config_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import status_mem_pkg::*;

    // ==========================================================================
    // stimulus and observation signals
    logic clk;
    logic rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic [13:0] ev;
    logic stack_extension_enable;
    logic stack_ext_set_allowed;
    logic [23:0] data_addr;
    logic [23:0] code_addr;
    sram_map_t sram_map;
    logic can_buffer_placement;
    logic [3:0] merged_chip_enable_sel;
    logic sram_data_hit;
    logic sram_code_hit;
    logic can0_hit;
    logic can1_hit;
    logic [3:0] chip_enable_enabled;
    logic [3:0] chip_enable_select;
    logic program_store_strobe;
    logic read_strobe;
    logic [2:0] in_service;
    logic [3:0] serial_active;
    logic serial_any_active;
    logic [7:0] rdv;
    int miscompares;
    int samples_checked;
    int sidx[4] = '{6, 4, 10, 8};
    logic [23:0] sram_hit_addr[3] = '{24'h00F000, 24'h000000, 24'h400FFF};
    logic [23:0] can_addr[4] = '{24'h00EE10, 24'h00EF10, 24'h4010FF, 24'h401100};

    // ==========================================================================
    // design under test; ev bundles every one-cycle event input
    status_and_memory_config_regs dut (
        .clk(clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pf_isr_enter(ev[0]), .hp_isr_enter(ev[1]), .lp_isr_enter(ev[2]), .return_from_interrupt(ev[3]),
        .port0_tx_start(ev[4]), .port0_tx_done_flag(ev[5]), .port0_rx_start(ev[6]), .port0_rx_done_flag(ev[7]),
        .port1_tx_start(ev[8]), .port1_tx_done_flag(ev[9]), .port1_rx_start(ev[10]), .port1_rx_done_flag(ev[11]),
        .stack_extension_enable(stack_extension_enable), .stack_ext_set_allowed(stack_ext_set_allowed),
        .data_addr(data_addr), .code_addr(code_addr), .onchip_sram_map(sram_map),
        .can_buffer_placement(can_buffer_placement), .merged_chip_enable_sel(merged_chip_enable_sel),
        .sram_data_hit(sram_data_hit), .sram_code_hit(sram_code_hit), .can0_hit(can0_hit), .can1_hit(can1_hit),
        .chip_enable_enabled(chip_enable_enabled), .chip_enable_select(chip_enable_select),
        .external_data_move_rd(ev[12]), .external_code_rd(ev[13]),
        .program_store_strobe(program_store_strobe), .read_strobe(read_strobe),
        .in_service(in_service), .serial_active(serial_active), .serial_any_active(serial_any_active)
    );

    // ==========================================================================
    // clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ==========================================================================
    // access tasks: drive after an edge, hold to the taking edge, sample at the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        rdv = reg_rdata;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one-cycle pulse on event input i; its effect is visible at the following falling edge
    task automatic pulse_m(input logic [13:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 14'h0000;
        @(negedge clk);
    endtask

    task automatic pulse(input int i);
        pulse_m(14'h0001 << i);
    endtask

    // key pair with a chosen idle gap between the two writes
    task automatic key(input int gap);
        wr(`UNLOCK_KEY_OFFSET, `UNLOCK_KEY_FIRST);
        idle(gap);
        wr(`UNLOCK_KEY_OFFSET, `UNLOCK_KEY_SECOND);
    endtask

    task automatic mcw(input int gap, input logic [7:0] d);
        key(0);
        idle(gap);
        wr(`MEMCFG_OFFSET, d);
    endtask

    task automatic put_addr(input logic [23:0] d, input logic [23:0] c);
        @(posedge clk);
        data_addr <= d;
        code_addr <= c;
        @(posedge clk);
        @(negedge clk);
    endtask

    // ==========================================================================
    // comparison and closing report
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        chk(rdv & ((a == `STATUS_OFFSET) ? 8'hEF : 8'hFF), exp);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done();
    end

    // ==========================================================================
    // main sequence
    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ev = 14'h0000;
        stack_extension_enable = 1'b0;
        data_addr = 24'h000000;
        code_addr = 24'h000000;
        chip_enable_enabled = 4'h0;
        chip_enable_select = 4'h0;
        miscompares = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rchk(`MEMCFG_OFFSET, 8'h10);
        rchk(`STATUS_OFFSET, 8'h00);
        chk(stack_ext_set_allowed, 8'h01);
        // protected and read-only places refuse plain writes
        wr(`MEMCFG_OFFSET, 8'hFF);
        rchk(`MEMCFG_OFFSET, 8'h10);
        wr(`STATUS_OFFSET, 8'hFF);
        rchk(`STATUS_OFFSET, 8'h00);
        mcw(0, 8'h6A);
        rchk(`MEMCFG_OFFSET, 8'h7A);
        chk(sram_map, 8'h01);
        chk(can_buffer_placement, 8'h01);
        chk(merged_chip_enable_sel, 8'h0A);
        // window edges: last open cycle, first closed cycle
        mcw(1, 8'h25);
        rchk(`MEMCFG_OFFSET, 8'h35);
        mcw(2, 8'h00);
        rchk(`MEMCFG_OFFSET, 8'h35);
        key(1);
        wr(`MEMCFG_OFFSET, 8'h40);
        rchk(`MEMCFG_OFFSET, 8'h50);
        key(2);
        wr(`MEMCFG_OFFSET, 8'h00);
        rchk(`MEMCFG_OFFSET, 8'h50);
        // shared map refused while stack extension is on, other bits still taken
        @(posedge clk);
        stack_extension_enable <= 1'h1;
        mcw(0, 8'hE3);
        rchk(`MEMCFG_OFFSET, 8'h73);
        @(posedge clk);
        stack_extension_enable <= 1'h0;
        mcw(0, 8'hC0);
        rchk(`MEMCFG_OFFSET, 8'hD0);
        chk(stack_ext_set_allowed, 8'h00);
        put_addr(24'h400ABC, 24'h400ABC);
        chk({sram_data_hit, sram_code_hit}, 8'h03);
        // sram placement for the data-only codes
        for (int m = 0; m < 3; m++) begin
            mcw(0, {m[1:0], 6'h10});
            chk(stack_ext_set_allowed, 8'h01);
            for (int j = 0; j < 3; j++) begin
                put_addr(sram_hit_addr[j], 24'h400000);
                chk({sram_data_hit, sram_code_hit}, {6'h00, j == m, 1'b0});
            end
        end
        // can buffer pair for both placements
        for (int p = 0; p < 2; p++) begin
            mcw(0, {2'b00, p[0], 5'h10});
            for (int j = 0; j < 4; j++) begin
                put_addr(can_addr[j], 24'h000000);
                chk({can0_hit, can1_hit}, {6'h00, j == 2 * p, j == 2 * p + 1});
            end
        end
        // strobe steering: merge bits 0101, enables 0011
        mcw(0, 8'h15);
        @(posedge clk);
        chip_enable_enabled <= 4'h3;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            chip_enable_select <= 4'h1 << i;
            pulse(12);
            chk({program_store_strobe, read_strobe}, (i == 0) ? 8'h02 : 8'h01);
        end
        pulse(13);
        chk({program_store_strobe, read_strobe}, 8'h02);
        // serial activity set and cleared by each port's own done flag
        for (int b = 0; b < 4; b++) begin
            pulse(sidx[b]);
            chk({serial_any_active, serial_active}, 8'h10 | (8'h01 << b));
            rchk(`STATUS_OFFSET, 8'h01 << b);
            pulse(sidx[b] + 1);
            chk({serial_any_active, serial_active}, 8'h00);
        end
        pulse(4);
        pulse(9);
        chk(serial_active, 8'h02);
        pulse(5);
        chk(serial_active, 8'h00);
        // start and done in one cycle: start wins, summary follows
        pulse_m(14'h00C0);
        chk({serial_any_active, serial_active}, 8'h11);
        pulse(7);
        chk({serial_any_active, serial_active}, 8'h00);
        // nested service levels unwind highest first
        pulse(2);
        pulse(1);
        pulse(0);
        rchk(`STATUS_OFFSET, 8'hE0);
        pulse(3);
        chk(in_service, 8'h03);
        pulse(3);
        chk(in_service, 8'h01);
        pulse(3);
        rchk(`STATUS_OFFSET, 8'h00);
        test_done();
    end
endmodule
